// ---- hdl/bacm_consts.svh ----
/*
  Offsets, field positions and reset values of the bus access classifier monitor.
  Assumes inclusion by bare name from the monitor and the bench.
*/
`ifndef BACM_CONSTS_SVH
`define BACM_CONSTS_SVH

// ===========================================================================
// Register offsets (byte addresses)
`define BACM_CTRL_OFF     8'h00
`define BACM_STATUS_OFF   8'h04
`define BACM_CNT_BASE_OFF 8'h10
`define BACM_CNT_LAST_OFF 8'h3C

// ===========================================================================
// Control and status fields
`define BACM_CTRL_SRC_BIT   0
`define BACM_CTRL_EN_BIT    1
`define BACM_CTRL_CLR_BIT   2
`define BACM_CTRL_RST       2'h2
`define BACM_STAT_WB_BIT    0

// ===========================================================================
// Cache line layout of write-backs
`define BACM_LINE_FIRST     5'h00
`define BACM_LINE_HALF      5'h10
`define BACM_WORD_STEP      5'h04
`define BACM_WB4_BEATS      3'h4
`define BACM_WB8_BEATS      3'h0

// ===========================================================================
// AXI responses
`define BACM_RESP_OKAY      2'h0
`define BACM_RESP_SLVERR    2'h2

`endif

// ---- hdl/bacm_pkg.sv ----
/*
  Types of the bus access classifier monitor: access classes and tracker states.
  Assumes bacm_consts.svh is reachable on the include path.
*/
package bacm_pkg;
  // =========================================================================
  // Access classes, also the counter index
  localparam int BACM_NCNT = 12;
  typedef enum logic [3:0] {
    CL_IFETCH  = 4'h0,
    CL_DLOAD   = 4'h1,
    CL_NBSTORE = 4'h2,
    CL_WB4     = 4'h3,
    CL_ILINE   = 4'h4,
    CL_DLINE   = 4'h5,
    CL_WB8     = 4'h6,
    CL_IWALK   = 4'h7,
    CL_DWALK   = 4'h8,
    CL_BSTORE  = 4'h9,
    CL_UNEXP   = 4'hA,
    CL_ERROR   = 4'hB
  } bacm_class_t;

  // =========================================================================
  // Write-back burst tracker, one-hot
  typedef enum logic [1:0] {
    WB_IDLE = 2'b01,
    WB_RUN  = 2'b10
  } bacm_wb_state_t;
endpackage : bacm_pkg

// ---- hdl/bacm_cnt_if.sv ----
/*
  Carrier between the monitor core and its counter bank.
  Assumes one clock shared by both ends.
*/
interface bacm_cnt_if;
  logic [11:0] inc;
  logic        clear;
  logic [31:0] count [12];

  modport ctl  (output inc, output clear, input count);
  modport bank (input inc, input clear, output count);
endinterface : bacm_cnt_if

// ---- hdl/bacm_counters.sv ----
/*
  Bank of twelve 32-bit event counters, each bumped by one on its pulse.
  Assumes aclk and synchronous active-low aresetn; clear wins over a bump.
*/
module bacm_counters (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Counter carrier
  bacm_cnt_if.bank cnt
);
  logic [31:0] count_r   [12];
  logic [31:0] count_nxt [12];

  always_comb begin
    for (int i = 0; i < 12; i++) begin
      count_nxt[i] = count_r[i];
      if (cnt.clear) begin
        count_nxt[i] = 32'h0000_0000;
      end else if (cnt.inc[i]) begin
        count_nxt[i] = count_r[i] + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge aclk) begin
    for (int i = 0; i < 12; i++) begin
      if (!aresetn) begin
        count_r[i] <= 32'h0000_0000;
      end else begin
        count_r[i] <= count_nxt[i];
      end
    end
  end

  assign cnt.count = count_r;
endmodule : bacm_counters

// ---- hdl/bacm_monitor.sv ----
/*
  Bus access classifier monitor: decodes each observed system bus beat into
  an access class, counts it, and exposes the counts over AXI4-Lite.
  Assumes all bus observation pins are asynchronous to aclk, a synchronous
  active-low reset, and one outstanding AXI read and write at a time.
*/
// Operation
// RULE_01: Direction and protection bit come from the native or the bus signals, per control.
// RULE_02: Code 00 reads are instruction fetches with protection 0 and data loads with 1.
// RULE_03: Code 00 writes with protection 1 are nonbuffered single or multiple stores.
// RULE_04: Code 01 writes with protection 1 are four-word dirty write-backs.
// RULE_05: Code 10 reads are eight-word linefills, instruction with 0 and data with 1.
// RULE_06: Code 10 writes with protection 1 are eight-word dirty write-backs.
// RULE_07: Code 11 reads are table walks by protection bit, writes with bit set buffered stores.
// RULE_08: Beats are observed only under core grant and qualified by error, last and wait.
// RULE_09: All counts are readable by software through the memory-mapped port.
// RULE_10: Four-word write-backs walk 0x00-0x0C or 0x10-0x1C, eight-word ones 0x00-0x1C.
// RULE_11: Unassigned code, direction and protection mixes go to a separate unexpected count.
// RULE_12: Each class counts once per completed beat, waits excluded, errors counted apart.
`include "bacm_consts.svh"

module bacm_monitor
  import bacm_pkg::*;
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Observed bus pins
  input  wire logic [1:0]  burst_code,
  input  wire logic        bus_write,
  input  wire logic        bus_prot0,
  input  wire logic        native_write_direction,
  input  wire logic        native_protection_bit0,
  input  wire logic        core_bus_grant,
  input  wire logic        data_phase,
  input  wire logic        slave_error,
  input  wire logic        slave_last,
  input  wire logic        slave_wait,
  input  wire logic [4:0]  addr_low,
  // AXI4-Lite write
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  // =========================================================================
  // Pin synchronisers
  logic [15:0] pin_s1_r;
  logic [15:0] pin_s2_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1_r <= 16'h0000;
      pin_s2_r <= 16'h0000;
    end else begin
      pin_s1_r <= {burst_code, bus_write, bus_prot0, native_write_direction,
                   native_protection_bit0, core_bus_grant, data_phase,
                   slave_error, slave_last, slave_wait, addr_low};
      pin_s2_r <= pin_s1_r;
    end
  end
  logic [1:0] code_s;
  logic       bwr_s, bpr_s, nwr_s, npr_s, gnt_s, act_s, err_s, last_s, wait_s;
  logic [4:0] addr_s;
  assign {code_s, bwr_s, bpr_s, nwr_s, npr_s, gnt_s, act_s,
          err_s, last_s, wait_s, addr_s} = pin_s2_r;

  // =========================================================================
  // Classification
  logic [1:0]  ctrl_r, ctrl_nxt;
  logic        wr_sel, pr_sel, beat_done;
  bacm_class_t cls;
  assign wr_sel = ctrl_r[`BACM_CTRL_SRC_BIT] ? nwr_s : bwr_s; // RULE_01
  assign pr_sel = ctrl_r[`BACM_CTRL_SRC_BIT] ? npr_s : bpr_s; // RULE_01

  always_comb begin
    case ({code_s, wr_sel, pr_sel})
      4'h0:    cls = CL_IFETCH;  // RULE_02
      4'h1:    cls = CL_DLOAD;   // RULE_02
      4'h3:    cls = CL_NBSTORE; // RULE_03
      4'h7:    cls = CL_WB4;     // RULE_04
      4'h8:    cls = CL_ILINE;   // RULE_05
      4'h9:    cls = CL_DLINE;   // RULE_05
      4'hB:    cls = CL_WB8;     // RULE_06
      4'hC:    cls = CL_IWALK;   // RULE_07
      4'hD:    cls = CL_DWALK;   // RULE_07
      4'hF:    cls = CL_BSTORE;  // RULE_07
      default: cls = CL_UNEXP;   // RULE_11
    endcase
  end

  // A retract (error with last) is neither a beat nor an error
  assign beat_done = ctrl_r[`BACM_CTRL_EN_BIT] && gnt_s && act_s && !wait_s
                     && !(err_s && last_s); // RULE_08 RULE_12

  // =========================================================================
  // Write-back burst tracker
  bacm_wb_state_t wb_st_r, wb_st_nxt;
  logic [4:0]     wb_addr_r, wb_addr_nxt;
  logic [2:0]     wb_left_r, wb_left_nxt;
  logic           wb_kind_r, wb_kind_nxt;
  logic           wb_beat, wb_bad, is_wb8;
  assign is_wb8  = (cls == CL_WB8);
  assign wb_beat = beat_done && !err_s && (cls == CL_WB4 || is_wb8);

  always_comb begin
    wb_st_nxt   = wb_st_r;
    wb_addr_nxt = wb_addr_r;
    wb_left_nxt = wb_left_r;
    wb_kind_nxt = wb_kind_r;
    wb_bad      = 1'b0;
    case (wb_st_r)
      WB_IDLE: begin
        if (wb_beat) begin
          if (addr_s == `BACM_LINE_FIRST
              || (!is_wb8 && addr_s == `BACM_LINE_HALF)) begin // RULE_10
            wb_st_nxt   = WB_RUN;
            wb_kind_nxt = is_wb8;
            wb_addr_nxt = addr_s + `BACM_WORD_STEP;
            wb_left_nxt = (is_wb8 ? `BACM_WB8_BEATS : `BACM_WB4_BEATS) - 3'h1;
          end else begin
            wb_bad = 1'b1; // RULE_10
          end
        end
      end
      WB_RUN: begin
        if (wb_beat) begin
          if (is_wb8 == wb_kind_r && addr_s == wb_addr_r) begin // RULE_10
            wb_addr_nxt = addr_s + `BACM_WORD_STEP;
            wb_left_nxt = wb_left_r - 3'h1;
            if (wb_left_r == 3'h1) begin
              wb_st_nxt = WB_IDLE;
            end
          end else begin
            wb_bad    = 1'b1;
            wb_st_nxt = WB_IDLE;
          end
        end else if (beat_done) begin
          wb_st_nxt = WB_IDLE;
        end
      end
      default: wb_st_nxt = WB_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wb_st_r   <= WB_IDLE;
      wb_addr_r <= 5'h00;
      wb_left_r <= 3'h0;
      wb_kind_r <= 1'b0;
    end else begin
      wb_st_r   <= wb_st_nxt;
      wb_addr_r <= wb_addr_nxt;
      wb_left_r <= wb_left_nxt;
      wb_kind_r <= wb_kind_nxt;
    end
  end

  // =========================================================================
  // Count pulses, registered so the counter bank sees a clean one-cycle bump
  logic [11:0] inc_r, inc_nxt;
  always_comb begin
    inc_nxt = 12'h000;
    if (beat_done) begin
      if (err_s) begin
        inc_nxt[CL_ERROR] = 1'b1; // RULE_12
      end else if (wb_bad) begin
        inc_nxt[CL_UNEXP] = 1'b1; // RULE_10 RULE_11
      end else begin
        inc_nxt[cls] = 1'b1; // RULE_12
      end
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      inc_r <= 12'h000;
    end else begin
      inc_r <= inc_nxt;
    end
  end

  bacm_cnt_if cnt ();
  logic clr_pulse;
  assign cnt.inc   = inc_r;
  assign cnt.clear = clr_pulse;
  bacm_counters u_counters (
    .aclk    (aclk),
    .aresetn (aresetn),
    .cnt     (cnt)
  );

  // =========================================================================
  // AXI4-Lite slave; address and data may arrive in either order
  logic        aw_got_r, aw_got_nxt, w_got_r, w_got_nxt, bvalid_nxt, rvalid_nxt;
  logic [7:0]  awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt, rdata_nxt;
  logic [3:0]  wstrb_r, wstrb_nxt;
  logic [1:0]  bresp_nxt, rresp_nxt;
  logic        wr_fire, wr_hit;
  assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_got_r && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_fire       = aw_got_r && w_got_r;
  assign wr_hit        = (awaddr_r == `BACM_CTRL_OFF);
  assign clr_pulse     = wr_fire && wr_hit && wstrb_r[0] && wdata_r[`BACM_CTRL_CLR_BIT];

  always_comb begin
    aw_got_nxt = aw_got_r;
    w_got_nxt  = w_got_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt  = wdata_r;
    wstrb_nxt  = wstrb_r;
    ctrl_nxt   = ctrl_r;
    bvalid_nxt = s_axi_bvalid && !s_axi_bready;
    bresp_nxt  = s_axi_bresp;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_got_nxt = 1'b1;
      awaddr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_got_nxt = 1'b1;
      wdata_nxt = s_axi_wdata;
      wstrb_nxt = s_axi_wstrb;
    end
    if (wr_fire) begin
      aw_got_nxt = 1'b0;
      w_got_nxt  = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt  = (wr_hit || awaddr_r == `BACM_STATUS_OFF
                   || (awaddr_r >= `BACM_CNT_BASE_OFF && awaddr_r <= `BACM_CNT_LAST_OFF
                       && awaddr_r[1:0] == 2'h0)) ? `BACM_RESP_OKAY : `BACM_RESP_SLVERR;
      if (wr_hit && wstrb_r[0]) begin
        ctrl_nxt = wdata_r[1:0]; // RULE_01
      end
    end
  end

  always_comb begin
    rvalid_nxt = s_axi_rvalid && !s_axi_rready;
    rdata_nxt  = s_axi_rdata;
    rresp_nxt  = s_axi_rresp;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = `BACM_RESP_OKAY;
      rdata_nxt  = 32'h0000_0000;
      if (s_axi_araddr == `BACM_CTRL_OFF) begin
        rdata_nxt[1:0] = ctrl_r;
      end else if (s_axi_araddr == `BACM_STATUS_OFF) begin
        rdata_nxt[`BACM_STAT_WB_BIT] = (wb_st_r == WB_RUN);
      end else if (s_axi_araddr >= `BACM_CNT_BASE_OFF && s_axi_araddr <= `BACM_CNT_LAST_OFF
                   && s_axi_araddr[1:0] == 2'h0) begin
        rdata_nxt = cnt.count[4'(s_axi_araddr[5:2] - 4'h4)]; // RULE_09
      end else begin
        rresp_nxt = `BACM_RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r     <= 1'b0;
      w_got_r      <= 1'b0;
      awaddr_r     <= 8'h00;
      wdata_r      <= 32'h0000_0000;
      wstrb_r      <= 4'h0;
      ctrl_r       <= `BACM_CTRL_RST;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `BACM_RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `BACM_RESP_OKAY;
    end else begin
      aw_got_r     <= aw_got_nxt;
      w_got_r      <= w_got_nxt;
      awaddr_r     <= awaddr_nxt;
      wdata_r      <= wdata_nxt;
      wstrb_r      <= wstrb_nxt;
      ctrl_r       <= ctrl_nxt;
      s_axi_bvalid <= bvalid_nxt;
      s_axi_bresp  <= bresp_nxt;
      s_axi_rvalid <= rvalid_nxt;
      s_axi_rdata  <= rdata_nxt;
      s_axi_rresp  <= rresp_nxt;
    end
  end

  // =========================================================================
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_beat(logic [3:0] key);
    beat_done && !err_s && !wb_bad && {code_s, wr_sel, pr_sel} == key;
  endsequence

  a_fetch_class: assert property (s_beat(4'h0) |=> inc_r[CL_IFETCH]) // RULE_02
    else $error("fetch beat not counted as fetch");
  a_nbstore_class: assert property (s_beat(4'h3) |=> inc_r[CL_NBSTORE]) // RULE_03
    else $error("nonbuffered store miscounted");
  a_wb4_class: assert property (s_beat(4'h7) |=> inc_r[CL_WB4]) // RULE_04
    else $error("four-word write-back miscounted");
  a_linefill_class: assert property (s_beat(4'h9) |=> inc_r[CL_DLINE]) // RULE_05
    else $error("data linefill miscounted");
  a_wb8_class: assert property (s_beat(4'hB) |=> inc_r[CL_WB8]) // RULE_06
    else $error("eight-word write-back miscounted");
  a_walk_class: assert property (s_beat(4'hC) |=> inc_r[CL_IWALK]) // RULE_07
    else $error("table walk miscounted");
  a_unexp_class: assert property (s_beat(4'h2) |=> inc_r[CL_UNEXP]) // RULE_11
    else $error("unassigned mix not flagged");
  a_wait_nocount: assert property (wait_s || !gnt_s |=> inc_r == 12'h000) // RULE_08
    else $error("count during wait or without grant");
  a_error_count: assert property (beat_done && err_s |=> inc_r == 12'h800) // RULE_12
    else $error("error beat not counted apart");
  a_wb_bad_start: assert property (wb_st_r == WB_IDLE && beat_done && !err_s && cls == CL_WB8
      && addr_s == 5'h10 |=> inc_r[CL_UNEXP]) // RULE_10
    else $error("misaligned write-back accepted");
  a_count_step: assert property (inc_r[CL_IFETCH] && !clr_pulse
      |=> cnt.count[0] == $past(cnt.count[0]) + 32'h0000_0001) // RULE_12
    else $error("counter did not step by one");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) // RULE_09
    else $error("read not answered next cycle");
endmodule : bacm_monitor

// ---- dv/bacm_bus_model.sv ----
/*
  Far-side model: the core's grant and transfer pins plus the slave responses.
  Assumes the bench calls its tasks one at a time from a single process.
*/
module bacm_bus_model (
  // Clock
  input  wire logic aclk,
  // Observed pins
  output logic [1:0] burst_code,
  output logic       bus_write,
  output logic       bus_prot0,
  output logic       native_write_direction,
  output logic       native_protection_bit0,
  output logic       core_bus_grant,
  output logic       data_phase,
  output logic       slave_error,
  output logic       slave_last,
  output logic       slave_wait,
  output logic [4:0] addr_low
);
  timeunit 1ns;
  timeprecision 1ns;

  bit native = 1'b0;

  initial begin
    {burst_code, bus_write, bus_prot0, native_write_direction, native_protection_bit0} = '0;
    {core_bus_grant, data_phase, slave_error, slave_last, slave_wait, addr_low} = '0;
  end

  // =========================================================================
  // One beat per clock; kind 0 done, 1 wait first, 2 no grant, 3 error, 4 retract
  task beat(input logic [1:0] c, input logic w, p, input logic [4:0] a, input int k);
    @(posedge aclk);
    {burst_code, addr_low, data_phase} <= {c, a, 1'b1};
    // The unused source carries the inverse, so a wrong pick miscounts
    {bus_write, bus_prot0} <= native ? {!w, !p} : {w, p};
    {native_write_direction, native_protection_bit0} <= native ? {w, p} : {!w, !p};
    core_bus_grant <= (k != 2);
    {slave_error, slave_last, slave_wait} <= {k >= 3, k == 4, k == 1};
    if (k == 1) begin
      @(posedge aclk);
      slave_wait <= 1'b0;
    end
  endtask : beat

  // Released code, address, bus write and bus protection lines show the inverse of their last value, not a stale copy; the native lines hold
  task idle(input int n);
    @(posedge aclk);
    {data_phase, slave_error, slave_last, slave_wait} <= 4'h0;
    {burst_code, addr_low, bus_write, bus_prot0} <= ~{burst_code, addr_low, bus_write, bus_prot0};
    repeat (n) @(posedge aclk);
  endtask : idle
endmodule : bacm_bus_model

// ---- dv/bacm_monitor_tb.sv ----
/*
  Self-checking bench of the bus access classifier monitor: drives the register
  port and the far-side model, and predicts every counter with an integer model.
  Assumes bacm_pkg is compiled first and bacm_consts.svh is on the include path.
*/
`include "bacm_consts.svh"

module bacm_monitor_tb import bacm_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ns;

  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [1:0]  burst_code;
  logic [4:0]  addr_low;
  logic        bus_write, bus_prot0, native_write_direction, native_protection_bit0;
  logic        core_bus_grant, data_phase, slave_error, slave_last, slave_wait;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, got_d;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, got_r, got_b;
  logic [31:0] r;
  logic        w, p;
  int          cnt_exp [BACM_NCNT];
  int          mismatches = 0, check_count = 0, wb_left = 0, wb_cls = 0, seed = 32'h1DC5;
  logic [4:0]  wb_adr = 5'h00;

  always #25 aclk = ~aclk;

  bacm_bus_model bfm (.aclk, .burst_code, .bus_write, .bus_prot0, .native_write_direction,
    .native_protection_bit0, .core_bus_grant, .data_phase, .slave_error, .slave_last,
    .slave_wait, .addr_low);

  bacm_monitor dut (.aclk, .aresetn, .burst_code, .bus_write, .bus_prot0,
    .native_write_direction, .native_protection_bit0, .core_bus_grant, .data_phase,
    .slave_error, .slave_last, .slave_wait, .addr_low, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  // =========================================================================
  // Reference model
  function automatic bacm_class_t cls(input logic [1:0] c, input logic w, p);
    if (w && p)
      return c == 2'h0 ? CL_NBSTORE : c == 2'h1 ? CL_WB4 : c == 2'h2 ? CL_WB8 : CL_BSTORE;
    if (w || c == 2'h1)
      return CL_UNEXP;
    if (c == 2'h0)
      return p ? CL_DLOAD : CL_IFETCH;
    return c == 2'h2 ? (p ? CL_DLINE : CL_ILINE) : (p ? CL_DWALK : CL_IWALK);
  endfunction : cls

  task automatic note(input logic [1:0] c, input logic w, p, input logic [4:0] a, input int k);
    int cl;
    if (k == 2 || k == 4)
      return;
    cl = (k == 3) ? int'(CL_ERROR) : int'(cls(c, w, p));
    if (cl == CL_WB4 || cl == CL_WB8) begin
      if (wb_left > 0 && cl == wb_cls && a === wb_adr)
        wb_left--;
      else if (wb_left == 0 && (a == 5'h00 || (cl == CL_WB4 && a == 5'h10))) begin
        wb_cls = cl;
        wb_left = (cl == CL_WB4) ? 3 : 7;
      end else begin
        cl = CL_UNEXP;
        wb_left = 0;
      end
      wb_adr = a + 5'h04;
    end else
      wb_left = 0;
    cnt_exp[cl]++;
  endtask : note

  task automatic go(input logic [1:0] c, input logic w, p, input logic [4:0] a, input int k);
    bfm.beat(c, w, p, a, k);
    note(c, w, p, a, k);
  endtask : go

  task automatic wb(input logic [1:0] c, input logic [4:0] a, input int n);
    for (int i = 0; i < n; i++)
      go(c, 1'b1, 1'b1, a + 5'(4 * i), 0);
  endtask : wb

  // =========================================================================
  // Register port
  task automatic take(ref logic v);
    logic t;
    do begin
      @(negedge aclk);
      t = v;
      {got_d, got_r, got_b} = {s_axi_rdata, s_axi_rresp, s_axi_bresp};
      @(posedge aclk);
    end while (!t);
  endtask : take

  task automatic axi_rd(input logic [7:0] a);
    @(posedge aclk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
    take(s_axi_arready);
    s_axi_arvalid <= 1'b0;
    take(s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask : axi_rd

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'h7};
    while (!(ta && tw)) begin
      @(negedge aclk);
      ta = ta || (s_axi_awvalid && s_axi_awready);
      tw = tw || (s_axi_wvalid && s_axi_wready);
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
    take(s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("write response", 32'(e), 32'(got_b));
  endtask : axi_wr

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask : chk

  task automatic chk_all;
    bfm.idle(6);
    for (int i = 0; i < BACM_NCNT; i++) begin
      axi_rd(`BACM_CNT_BASE_OFF + 8'(4 * i));
      chk($sformatf("counter %0d", i), cnt_exp[i], got_d);
    end
  endtask : chk_all

  task conclude;
    if (mismatches == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : conclude

  // =========================================================================
  // Scenarios
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(`BACM_CTRL_OFF);
    chk("control", 32'(`BACM_CTRL_RST), got_d);
    chk("control response", 32'(`BACM_RESP_OKAY), 32'(got_r));
    axi_rd(8'h08);
    chk("unmapped response", 32'(`BACM_RESP_SLVERR), 32'(got_r));
    chk("unmapped data", 32'h0, got_d);
    axi_wr(`BACM_CNT_BASE_OFF, 32'h5A5A_5A5A, `BACM_RESP_OKAY);
    axi_wr(8'h08, 32'h0000_0003, `BACM_RESP_SLVERR);
    chk_all;
    // Every code, direction and protection mix from both sources
    for (int s = 0; s < 2; s++) begin
      axi_wr(`BACM_CTRL_OFF, {29'h0, 2'h1, s[0]}, `BACM_RESP_OKAY);
      bfm.native = s[0];
      for (int i = 0; i < 16; i++)
        go(i[3:2], i[1], i[0], 5'h00, 0);
      chk_all;
    end
    axi_wr(`BACM_CTRL_OFF, 32'h2, `BACM_RESP_OKAY);
    bfm.native = 1'b0;
    wb(2'h1, 5'h10, 4);
    wb(2'h2, 5'h00, 8);
    wb(2'h1, 5'h08, 1);
    wb(2'h1, 5'h00, 2);
    bfm.idle(6);
    axi_rd(`BACM_STATUS_OFF);
    chk("status busy", 32'h1, got_d);
    wb(2'h1, 5'h08, 2);
    bfm.idle(6);
    axi_rd(`BACM_STATUS_OFF);
    chk("status done", 32'h0, got_d);
    wb(2'h1, 5'h00, 1);
    wb(2'h1, 5'h0C, 1);
    // An eight-word write-back may not start mid-line
    wb(2'h2, 5'h10, 1);
    go(2'h0, 1'b0, 1'b0, 5'h00, 0);
    wb(2'h1, 5'h00, 2);
    go(2'h0, 1'b0, 1'b0, 5'h00, 0);
    wb(2'h1, 5'h10, 4);
    chk_all;
    for (int k = 1; k < 5; k++)
      go(2'h0, 1'b0, 1'b1, 5'h00, k);
    chk_all;
    for (int n = 0; n < 60; n++) begin
      r = $random(seed);
      {w, p} = r[3:2];
      if (cls(r[1:0], w, p) inside {CL_WB4, CL_WB8})
        p = 1'b0;
      go(r[1:0], w, p, r[8:4], int'(r[15:12]) % 5);
    end
    chk_all;
    axi_wr(`BACM_CTRL_OFF, 32'h0, `BACM_RESP_OKAY);
    bfm.beat(2'h0, 1'b0, 1'b0, 5'h00, 0);
    chk_all;
    axi_wr(`BACM_CTRL_OFF, 32'h6, `BACM_RESP_OKAY);
    cnt_exp = '{default: 0};
    axi_rd(`BACM_CTRL_OFF);
    chk("control", 32'h2, got_d);
    chk_all;
    conclude;
  end

  initial begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    conclude;
  end
endmodule : bacm_monitor_tb
